// ===== hdl/crypto_self_test_sequencer.sv
`timescale 1ns/100ps
`default_nettype none

module crypto_self_test_sequencer #(
   parameter int n_tests = self_test_pkg::num_tests,
   parameter int retest_count = self_test_pkg::retest_cycles
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic fw_available_irq,
   input wire logic [self_test_pkg::digest_w-1:0] root_public_key_digest,
   input wire logic [self_test_pkg::digest_w-1:0] root_key_reference_digest,
   input wire logic fw_signature_ok,
   input wire logic integrity_done,
   output logic integrity_start,
   output self_test_pkg::kat_cmd_type kat_cmd,
   input wire self_test_pkg::kat_rsp_type kat_rsp,
   input wire logic sleep_req,
   output logic sleep_ack,
   input wire logic wake_req,
   input wire logic recheck_req,
   input wire self_test_pkg::svc_req_type svc_req,
   output self_test_pkg::svc_rsp_type svc_rsp,
   input wire logic keygen_done,
   input wire logic pairwise_consistency_check_ok,
   output logic key_usable,
   input wire logic entropy_health_fail,
   input wire logic [self_test_pkg::seed_w-1:0] entropy_input,
   input wire logic [self_test_pkg::seed_w-1:0] entropy_nonce,
   input wire logic entropy_valid,
   output logic [2*self_test_pkg::seed_w-1:0] drbg_seed,
   output logic drbg_seed_valid,
   input wire logic freq_out_of_range,
   input wire logic officer_login,
   output logic officer_authenticated,
   output logic crypto_enable,
   output logic [self_test_pkg::log_addr_w-1:0] log_rd_addr,
   output logic log_rd_data
);

   // ****************************************************
   // sequencing state
   // ****************************************************
   self_test_pkg::state_type state_ff, nxt_state;
   logic [self_test_pkg::test_idx_w-1:0] idx_ff, nxt_idx;
   logic [31:0] timer_ff, nxt_timer;
   logic boot_ff, nxt_boot;
   logic kat_busy_ff, nxt_kat_busy;
   logic sleep_pend_ff, nxt_sleep_pend;
   logic [31:0] code_ff, nxt_code;
   logic start_pulse;
   logic digest_ok;
   logic last_idx;

   assign digest_ok = (root_public_key_digest == root_key_reference_digest);
   assign last_idx = (idx_ff == self_test_pkg::test_idx_w'(n_tests - 1));

   always_comb
   begin
      nxt_state = state_ff;
      nxt_idx = idx_ff;
      nxt_timer = timer_ff;
      nxt_boot = boot_ff;
      nxt_kat_busy = kat_busy_ff;
      nxt_sleep_pend = sleep_pend_ff;
      nxt_code = code_ff;
      start_pulse = 1'b0;
      case (state_ff)
         self_test_pkg::st_wait_fw:
         begin
            if (fw_available_irq)
            begin
               nxt_state = self_test_pkg::st_integrity;
               nxt_boot = 1'b1;
            end
         end
         self_test_pkg::st_integrity:
         begin
            if (integrity_done)
            begin
               if (!digest_ok || !fw_signature_ok)
               begin
                  nxt_state = self_test_pkg::st_locked;
                  nxt_code = self_test_pkg::code_locked;
               end
               else if (boot_ff)
               begin
                  nxt_state = self_test_pkg::st_kat_run;
                  nxt_idx = self_test_pkg::first_test;
               end
               else
               begin
                  nxt_state = self_test_pkg::st_operational;
               end
            end
         end
         self_test_pkg::st_kat_run:
         begin
            // boot run walks every test back to back
            if (!kat_busy_ff)
            begin
               start_pulse = 1'b1;
               nxt_kat_busy = 1'b1;
            end
            else if (kat_rsp.done)
            begin
               nxt_kat_busy = 1'b0;
               if (!kat_rsp.pass)
               begin
                  nxt_state = self_test_pkg::st_abort;
                  nxt_code = self_test_pkg::code_abort;
               end
               else if (last_idx)
               begin
                  nxt_idx = self_test_pkg::first_test;
                  nxt_boot = 1'b0;
                  nxt_timer = 32'(retest_count);
                  nxt_state = self_test_pkg::st_operational;
               end
               else
               begin
                  nxt_idx = idx_ff + 4'h1;
               end
            end
         end
         self_test_pkg::st_operational:
         begin
            if (kat_busy_ff)
            begin
               if (kat_rsp.done)
               begin
                  nxt_kat_busy = 1'b0;
                  nxt_idx = last_idx ? self_test_pkg::first_test : idx_ff + 4'h1;
                  if (!kat_rsp.pass)
                  begin
                     nxt_state = self_test_pkg::st_abort;
                     nxt_code = self_test_pkg::code_abort;
                  end
                  else if (sleep_pend_ff)
                  begin
                     nxt_sleep_pend = 1'b0;
                     nxt_state = self_test_pkg::st_sleep;
                  end
               end
            end
            else if (sleep_req || sleep_pend_ff)
            begin
               // pending test runs first, then sleep
               start_pulse = 1'b1;
               nxt_kat_busy = 1'b1;
               nxt_sleep_pend = 1'b1;
            end
            else if (recheck_req)
            begin
               nxt_state = self_test_pkg::st_integrity;
            end
            else if (timer_ff <= 32'h0000_0001)
            begin
               start_pulse = 1'b1;
               nxt_kat_busy = 1'b1;
               nxt_timer = 32'(retest_count);
            end
            else
            begin
               nxt_timer = timer_ff - 32'h0000_0001;
            end
            if (entropy_health_fail)
            begin
               nxt_state = self_test_pkg::st_abort;
               nxt_code = self_test_pkg::code_abort;
            end
         end
         self_test_pkg::st_sleep:
         begin
            // timer held frozen while asleep
            if (wake_req)
            begin
               nxt_state = self_test_pkg::st_operational;
            end
         end
         default:
         begin
            // locked and abort have no exit but reset
            nxt_state = state_ff;
         end
      endcase
      if (entropy_health_fail && state_ff == self_test_pkg::st_kat_run)
      begin
         nxt_state = self_test_pkg::st_abort;
         nxt_code = self_test_pkg::code_abort;
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_ff <= self_test_pkg::st_wait_fw;
         idx_ff <= self_test_pkg::first_test;
         timer_ff <= 32'h0000_0000;
         boot_ff <= 1'b0;
         kat_busy_ff <= 1'b0;
         sleep_pend_ff <= 1'b0;
         code_ff <= self_test_pkg::code_none;
      end
      else
      begin
         state_ff <= nxt_state;
         idx_ff <= nxt_idx;
         timer_ff <= nxt_timer;
         boot_ff <= nxt_boot;
         kat_busy_ff <= nxt_kat_busy;
         sleep_pend_ff <= nxt_sleep_pend;
         code_ff <= nxt_code;
      end
   end

   assign integrity_start = (state_ff == self_test_pkg::st_integrity);
   assign kat_cmd.start = start_pulse;
   assign kat_cmd.index = idx_ff;
   assign sleep_ack = (state_ff == self_test_pkg::st_sleep);
   assign crypto_enable = (state_ff == self_test_pkg::st_operational) && !freq_out_of_range;

   // ****************************************************
   // service answers, keys, seed and officer login
   // ****************************************************
   self_test_pkg::svc_rsp_type rsp_ff, nxt_rsp;
   logic key_ok_ff, nxt_key_ok;
   logic auth_ff, nxt_auth;
   logic [2*self_test_pkg::seed_w-1:0] seed_ff, nxt_seed;
   logic seed_v_ff, nxt_seed_v;
   logic in_error;

   assign in_error = (state_ff == self_test_pkg::st_locked) ||
                     (state_ff == self_test_pkg::st_abort);

   always_comb
   begin
      nxt_rsp.valid = svc_req.valid;
      nxt_rsp.error_code = code_ff;
      nxt_rsp.self_test_failure_response = svc_req.valid && !svc_req.is_status &&
                                           (in_error || !crypto_enable);
      nxt_key_ok = key_ok_ff;
      if (keygen_done)
      begin
         nxt_key_ok = pairwise_consistency_check_ok && crypto_enable;
      end
      else if (!crypto_enable)
      begin
         nxt_key_ok = 1'b0;
      end
      nxt_auth = auth_ff;
      if (freq_out_of_range || in_error)
      begin
         nxt_auth = 1'b0;
      end
      else if (officer_login)
      begin
         nxt_auth = 1'b1;
      end
      nxt_seed = seed_ff;
      nxt_seed_v = seed_v_ff;
      if (entropy_valid && !entropy_health_fail && crypto_enable)
      begin
         nxt_seed = {entropy_input, entropy_nonce};
         nxt_seed_v = 1'b1;
      end
      else if (!crypto_enable)
      begin
         nxt_seed_v = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rsp_ff <= '0;
         key_ok_ff <= 1'b0;
         auth_ff <= 1'b0;
         seed_ff <= '0;
         seed_v_ff <= 1'b0;
      end
      else
      begin
         rsp_ff <= nxt_rsp;
         key_ok_ff <= nxt_key_ok;
         auth_ff <= nxt_auth;
         seed_ff <= nxt_seed;
         seed_v_ff <= nxt_seed_v;
      end
   end

   assign svc_rsp = rsp_ff;
   assign key_usable = key_ok_ff;
   assign officer_authenticated = auth_ff;
   assign drbg_seed = seed_ff;
   assign drbg_seed_valid = seed_v_ff;

   // ****************************************************
   // outcome log
   // ****************************************************
   assign log_rd_addr = idx_ff;

   test_log_mem #(
      .depth(self_test_pkg::log_depth),
      .addr_w(self_test_pkg::log_addr_w)
   ) u_log (
      .clk(clk),
      .wr_en(kat_busy_ff && kat_rsp.done),
      .wr_addr(idx_ff),
      .wr_data(kat_rsp.pass),
      .rd_addr(idx_ff),
      .rd_data(log_rd_data)
   );

   // ****************************************************
   // checks
   // ****************************************************
   a_locked_code: assert property (@(posedge clk) disable iff (!arst_n)
      state_ff == self_test_pkg::st_integrity && integrity_done && !digest_ok
      |=> state_ff == self_test_pkg::st_locked && code_ff == self_test_pkg::code_locked)
      else $error("integrity failure did not lock");

   a_abort_code: assert property (@(posedge clk) disable iff (!arst_n)
      state_ff == self_test_pkg::st_kat_run && kat_busy_ff && kat_rsp.done && !kat_rsp.pass
      |=> state_ff == self_test_pkg::st_abort && code_ff == self_test_pkg::code_abort)
      else $error("test failure did not abort");

   a_crypto_blocked: assert property (@(posedge clk) disable iff (!arst_n)
      crypto_enable |-> !boot_ff && !in_error)
      else $error("crypto enabled before tests passed");

   a_error_sticky: assert property (@(posedge clk) disable iff (!arst_n)
      in_error |=> $stable(state_ff))
      else $error("error state left without reset");

   a_status_only: assert property (@(posedge clk) disable iff (!arst_n)
      in_error && svc_req.valid && !svc_req.is_status
      |=> svc_rsp.valid && svc_rsp.self_test_failure_response)
      else $error("service not refused in error state");

   sequence s_timer_expiry;
      state_ff == self_test_pkg::st_operational && !kat_busy_ff && !sleep_req &&
      !sleep_pend_ff && !recheck_req && timer_ff == 32'h0000_0001;
   endsequence

   a_retest_start: assert property (@(posedge clk) disable iff (!arst_n)
      s_timer_expiry |-> kat_cmd.start ##1 kat_busy_ff)
      else $error("retest timer expiry did not start test");

   a_sleep_timer: assert property (@(posedge clk) disable iff (!arst_n)
      state_ff == self_test_pkg::st_sleep |=> $stable(timer_ff))
      else $error("retest timer ran during sleep");

   a_freq_auth: assert property (@(posedge clk) disable iff (!arst_n)
      freq_out_of_range |-> !crypto_enable ##1 !officer_authenticated)
      else $error("frequency alarm did not clear authentication");

   a_idx_wrap: assert property (@(posedge clk) disable iff (!arst_n)
      state_ff == self_test_pkg::st_operational && kat_busy_ff && kat_rsp.done && last_idx
      |=> idx_ff == self_test_pkg::first_test)
      else $error("test index did not wrap");

endmodule : crypto_self_test_sequencer

`default_nettype wire

// ===== hdl/self_test_pkg.sv
package self_test_pkg;

   localparam int num_tests = 12;
   localparam int test_idx_w = 4;
   localparam logic [test_idx_w-1:0] first_test = 4'h0;
   localparam logic [31:0] code_none = 32'h0000_0000;
   localparam logic [31:0] code_locked = 32'h0000_ff29;
   localparam logic [31:0] code_abort = 32'h471e_ed29;
   localparam int retest_period_ns = 1000000;
   localparam int clk_period_ns = 50;
   localparam int retest_cycles = retest_period_ns / clk_period_ns;
   localparam int digest_w = 512;
   localparam int seed_w = 256;
   localparam int log_depth = 16;
   localparam int log_addr_w = 4;

   typedef enum logic [6:0]
   {
      st_wait_fw = 7'h01,
      st_integrity = 7'h02,
      st_kat_run = 7'h04,
      st_operational = 7'h08,
      st_sleep = 7'h10,
      st_locked = 7'h20,
      st_abort = 7'h40
   } state_type;

   typedef struct packed
   {
      logic valid;
      logic is_status;
   } svc_req_type;

   typedef struct packed
   {
      logic valid;
      logic self_test_failure_response;
      logic [31:0] error_code;
   } svc_rsp_type;

   typedef struct packed
   {
      logic start;
      logic [test_idx_w-1:0] index;
   } kat_cmd_type;

   typedef struct packed
   {
      logic done;
      logic pass;
   } kat_rsp_type;

endpackage : self_test_pkg

// ===== hdl/test_log_mem.sv
`timescale 1ns/100ps
`default_nettype none

// small record of known-answer test outcomes, read out through a register
module test_log_mem #(
   parameter int depth = self_test_pkg::log_depth,
   parameter int addr_w = self_test_pkg::log_addr_w
) (
   input wire logic clk,
   input wire logic wr_en,
   input wire logic [addr_w-1:0] wr_addr,
   input wire logic wr_data,
   input wire logic [addr_w-1:0] rd_addr,
   output logic rd_data
);

   logic mem [depth];
   logic rd_data_ff;

   always_ff @(posedge clk)
   begin
      if (wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
      rd_data_ff <= mem[rd_addr];
   end

   assign rd_data = rd_data_ff;

endmodule : test_log_mem

`default_nettype wire

// ===== testbench/crypto_self_test_sequencer_tb.sv
`timescale 1ns/100ps
`default_nettype none

module crypto_self_test_sequencer_tb;
   localparam int n = 12;
   // short retest period keeps the run brief
   localparam int rt = 20;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic irq = 1'b0, sleep_req = 1'b0, wake_req = 1'b0, recheck_req = 1'b0;
   logic keygen_done = 1'b0, pct_ok = 1'b0, health_fail = 1'b0, ent_valid = 1'b0;
   logic freq_bad = 1'b0, login = 1'b0, fail_en = 1'b0, slow = 1'b0;
   logic [3:0] fail_idx = 4'h0;
   logic [511:0] key_dig = '0, ref_dig = '0;
   logic [255:0] ent_in = '0, ent_nonce = '0;
   self_test_pkg::svc_req_type svc_req = '0;
   logic integrity_done, integrity_start, fw_signature_ok, sleep_ack, key_usable;
   logic drbg_seed_valid, officer_authenticated, crypto_enable, log_rd_data;
   logic [3:0] log_rd_addr;
   logic [511:0] drbg_seed;
   self_test_pkg::kat_cmd_type kat_cmd;
   self_test_pkg::kat_rsp_type kat_rsp;
   self_test_pkg::svc_rsp_type svc_rsp;
   logic [32:0] exp_q[$];
   logic [3:0] kat_exp;
   logic [31:0] rnd = 32'h0000_001b;
   int err_count = 0, checked = 0, kat_seen = 0, cyc = 0, i, k;

   always #25 clk = ~clk;

   crypto_self_test_sequencer #(.n_tests(n), .retest_count(rt)) DUT (
      .clk(clk), .arst_n(arst_n), .fw_available_irq(irq),
      .root_public_key_digest(key_dig), .root_key_reference_digest(ref_dig),
      .fw_signature_ok(fw_signature_ok), .integrity_done(integrity_done),
      .integrity_start(integrity_start), .kat_cmd(kat_cmd), .kat_rsp(kat_rsp),
      .sleep_req(sleep_req), .sleep_ack(sleep_ack), .wake_req(wake_req),
      .recheck_req(recheck_req), .svc_req(svc_req), .svc_rsp(svc_rsp),
      .keygen_done(keygen_done), .pairwise_consistency_check_ok(pct_ok),
      .key_usable(key_usable), .entropy_health_fail(health_fail),
      .entropy_input(ent_in), .entropy_nonce(ent_nonce), .entropy_valid(ent_valid),
      .drbg_seed(drbg_seed), .drbg_seed_valid(drbg_seed_valid),
      .freq_out_of_range(freq_bad), .officer_login(login),
      .officer_authenticated(officer_authenticated), .crypto_enable(crypto_enable),
      .log_rd_addr(log_rd_addr), .log_rd_data(log_rd_data));

   fw_engine_model engines (
      .clk(clk), .arst_n(arst_n), .integrity_start(integrity_start),
      .kat_cmd(kat_cmd), .fail_en(fail_en), .fail_idx(fail_idx), .slow(slow),
      .integrity_done(integrity_done), .fw_signature_ok(fw_signature_ok),
      .kat_rsp(kat_rsp));

   // ********************************************************
   // shared tasks
   // ********************************************************
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic check(input logic [511:0] seen, input logic [511:0] exp);
      checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask : check

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : conclude

   task automatic tick(input int c);
      repeat (c) @(posedge clk);
   endtask : tick

   task automatic svc(input logic st, input logic [32:0] exp);
      exp_q.push_back(exp);
      svc_req <= '{1'b1, st};
      @(posedge clk);
      svc_req <= '0;
      @(posedge clk);
   endtask : svc

   task automatic do_reset;
      arst_n <= 1'b0;
      fail_en <= 1'b0;
      key_dig <= {16{rnd}};
      ref_dig <= {16{rnd}};
      tick(2);
      kat_seen = 0;
      arst_n <= 1'b1;
      @(posedge clk);
   endtask : do_reset

   task automatic boot(input logic bad_key, input logic fail, input logic [3:0] idx);
      fail_en <= fail;
      fail_idx <= idx;
      if (bad_key)
         key_dig[0] <= ~ref_dig[0];
      irq <= 1'b1;
      @(posedge clk);
      irq <= 1'b0;
      for (i = 0; i < 200 && crypto_enable !== 1'b1; i++)
         @(posedge clk);
   endtask : boot

   task automatic pulse_all_requests;
      recheck_req <= 1'b1;
      wake_req <= 1'b1;
      irq <= 1'b1;
      @(posedge clk);
      recheck_req <= 1'b0;
      wake_req <= 1'b0;
      irq <= 1'b0;
      tick(10);
   endtask : pulse_all_requests

   // ********************************************************
   // watchers: responses against noted expectations
   // ********************************************************
   always @(posedge clk)
   begin
      cyc++;
      rnd <= lfsr(rnd);
      slow <= rnd[3];
      if (cyc == 6000)
      begin
         err_count++;
         conclude();
      end
      else if (svc_rsp.valid === 1'b1)
      begin
         if (exp_q.size() == 0)
            check(1'b1, 1'b0);
         else
            check({svc_rsp.self_test_failure_response, svc_rsp.error_code}, exp_q.pop_front());
      end
   end

   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         kat_exp <= self_test_pkg::first_test;
      else if (kat_cmd.start === 1'b1)
      begin
         check(kat_cmd.index, kat_exp);
         kat_exp <= (kat_exp == 4'(n - 1)) ? 4'h0 : kat_exp + 4'h1;
         kat_seen++;
      end
   end

   // ********************************************************
   // scenarios
   // ********************************************************
   initial
   begin
      do_reset();
      svc(1'b0, {1'b1, self_test_pkg::code_none});
      check(crypto_enable, 1'b0);
      boot(1'b0, 1'b0, 4'h0);
      check(crypto_enable, 1'b1);
      check(512'(kat_seen), 512'(n));
      svc(1'b0, {1'b0, self_test_pkg::code_none});
      check(log_rd_addr, self_test_pkg::first_test);
      check(log_rd_data, 1'b1);
      $display("boot test finished");
      k = kat_seen;
      // held until taken: a request that meets a running retest is not latched
      sleep_req <= 1'b1;
      for (i = 0; i < 50 && sleep_ack !== 1'b1; i++)
         @(posedge clk);
      sleep_req <= 1'b0;
      check(512'(kat_seen - k), 512'(1));
      tick(3 * rt);
      check(512'(kat_seen - k), 512'(1));
      check(sleep_ack, 1'b1);
      wake_req <= 1'b1;
      @(posedge clk);
      wake_req <= 1'b0;
      tick(3 * rt + 10);
      check(kat_seen - k >= 3, 1'b1);
      $display("sleep and retest test finished");
      login <= 1'b1;
      @(posedge clk);
      login <= 1'b0;
      @(posedge clk);
      check(officer_authenticated, 1'b1);
      freq_bad <= 1'b1;
      tick(2);
      check(officer_authenticated, 1'b0);
      check(crypto_enable, 1'b0);
      freq_bad <= 1'b0;
      tick(2);
      check(officer_authenticated, 1'b0);
      for (k = 0; k < 2; k++)
      begin
         pct_ok <= !k[0];
         keygen_done <= 1'b1;
         @(posedge clk);
         keygen_done <= 1'b0;
         @(posedge clk);
         check(key_usable, !k[0]);
      end
      ent_in <= {8{rnd}};
      ent_nonce <= {8{~rnd}};
      ent_valid <= 1'b1;
      @(posedge clk);
      ent_valid <= 1'b0;
      @(posedge clk);
      check(drbg_seed, {ent_in, ent_nonce});
      check(drbg_seed_valid, 1'b1);
      recheck_req <= 1'b1;
      for (i = 0; i < 20 && integrity_start !== 1'b1; i++)
         @(posedge clk);
      recheck_req <= 1'b0;
      check(integrity_start, 1'b1);
      for (i = 0; i < 50 && crypto_enable !== 1'b1; i++)
         @(posedge clk);
      check(crypto_enable, 1'b1);
      health_fail <= 1'b1;
      @(posedge clk);
      health_fail <= 1'b0;
      svc(1'b0, {1'b1, self_test_pkg::code_abort});
      pulse_all_requests();
      svc(1'b0, {1'b1, self_test_pkg::code_abort});
      svc(1'b1, {1'b0, self_test_pkg::code_abort});
      do_reset();
      svc(1'b0, {1'b1, self_test_pkg::code_none});
      $display("operational services test finished");
      boot(1'b0, 1'b1, 4'h5);
      check(512'(kat_seen), 512'(6));
      check(crypto_enable, 1'b0);
      svc(1'b0, {1'b1, self_test_pkg::code_abort});
      check(log_rd_addr, 4'h5);
      check(log_rd_data, 1'b0);
      $display("abort test finished");
      do_reset();
      boot(1'b1, 1'b0, 4'h0);
      check(512'(kat_seen), 512'(0));
      svc(1'b0, {1'b1, self_test_pkg::code_locked});
      pulse_all_requests();
      svc(1'b1, {1'b0, self_test_pkg::code_locked});
      check(crypto_enable, 1'b0);
      $display("locked test finished");
      tick(2);
      check(512'(exp_q.size()), 512'(0));
      conclude();
   end
endmodule : crypto_self_test_sequencer_tb

`default_nettype wire

// ===== testbench/fw_engine_model.sv
`timescale 1ns/100ps
`default_nettype none

// ********************************************************
// integrity engine and test engine seen from the sequencer
// ********************************************************
// slow stretches every reply; between replies the result bits toggle so
// that a stale value is never mistaken for a fresh one
module fw_engine_model (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic integrity_start,
   input wire self_test_pkg::kat_cmd_type kat_cmd,
   input wire logic fail_en,
   input wire logic [self_test_pkg::test_idx_w-1:0] fail_idx,
   input wire logic slow,
   output logic integrity_done,
   output logic fw_signature_ok,
   output self_test_pkg::kat_rsp_type kat_rsp
);
   logic [2:0] icnt;
   logic [2:0] kcnt;
   logic ibusy;
   logic kbad;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         icnt <= 3'h0;
         kcnt <= 3'h0;
         ibusy <= 1'b0;
         kbad <= 1'b0;
         integrity_done <= 1'b0;
         fw_signature_ok <= 1'b0;
         kat_rsp <= '0;
      end
      else
      begin
         integrity_done <= 1'b0;
         fw_signature_ok <= ~fw_signature_ok;
         kat_rsp.done <= 1'b0;
         kat_rsp.pass <= ~kat_rsp.pass;
         // one check per rising request; a held request is not served twice
         if (!integrity_start)
            ibusy <= 1'b0;
         else if (!ibusy)
         begin
            ibusy <= 1'b1;
            icnt <= slow ? 3'h5 : 3'h2;
         end
         if (icnt != 3'h0)
            icnt <= icnt - 3'h1;
         if (icnt == 3'h1)
         begin
            integrity_done <= 1'b1;
            fw_signature_ok <= 1'b1;
         end
         if (kat_cmd.start)
         begin
            kcnt <= slow ? 3'h4 : 3'h1;
            kbad <= fail_en && (kat_cmd.index == fail_idx);
         end
         else if (kcnt != 3'h0)
            kcnt <= kcnt - 3'h1;
         if (kcnt == 3'h1)
         begin
            kat_rsp.done <= 1'b1;
            kat_rsp.pass <= ~kbad;
         end
      end
   end
endmodule : fw_engine_model

`default_nettype wire
